// >>> rtl/rfs_frame_classify.v
`timescale 1ns/100ps
`include "rfs_map.vh"

// ====================================================================
// Turns one end-of-frame strobe into per-counter increment requests.
module rfs_frame_classify #(
	parameter LEN_W = 16
) (
	input  wire             frameDone,
	input  wire [LEN_W-1:0] frameLen,
	input  wire             frameResidual,
	input  wire             frameMcast,
	input  wire [LEN_W-1:0] maxLen,
	output wire             incShort,
	output wire             incLong,
	output wire             incResid,
	output wire             incMcast
);
	assign incShort = frameDone && (frameLen < `RFS_SHORT_LIMIT);
	// Strictly greater, and residual frames go elsewhere.
	assign incLong  = frameDone && !frameResidual &&
	                  (frameLen > maxLen);
	assign incResid = frameDone && frameResidual;
	assign incMcast = frameDone && frameMcast;
endmodule

// >>> rtl/rfs_map.vh
`ifndef RFS_MAP_VH
`define RFS_MAP_VH

// ====================================================================
// Register byte addresses
`define RFS_SHORT_OFS        8'h00
`define RFS_LONG_OFS         8'h04
`define RFS_RESID_OFS        8'h08
`define RFS_MCAST_OFS        8'h0C
`define RFS_MAXLEN_OFS       8'h10
`define RFS_IRQ_STAT_OFS     8'h14
`define RFS_IRQ_MASK_OFS     8'h18

// ====================================================================
// Field layout and reset values
`define RFS_CNT_W            16
`define RFS_CNT_MAX          16'hFFFF
`define RFS_CNT_RST          16'h0000
`define RFS_LEN_W            16
`define RFS_MAXLEN_RST       16'h05EE
`define RFS_SHORT_LIMIT      16'h0040
`define RFS_NUM_CNT          4
`define RFS_IRQ_RST          4'h0

// ====================================================================
// Counter indexes, also the status and mask bit positions
`define RFS_IDX_SHORT        0
`define RFS_IDX_LONG         1
`define RFS_IDX_RESID        2
`define RFS_IDX_MCAST        3

`endif

// >>> rtl/rfs_rx_stats.v
`timescale 1ns/100ps
`include "rfs_map.vh"

// Function
// - Count received frames shorter than 64 bytes in 16 bits.
// - Any write to a counter register clears it, whatever the data.
// - Upper sixteen bits of every counter register read as zero.
// - Count frames longer than the programmed maximum in 16 bits.
// - Oversize means strictly greater than the programmed maximum.
// - A frame with residual bits is never counted as oversize.
// - Count frames ending with residual bits in 16 bits.
// - Count frames with a multicast destination in 16 bits.
module rfs_rx_stats (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        frameDone,
	input  wire [15:0] frameLen,
	input  wire        frameResidual,
	input  wire        frameMcast,
	output wire        irq
);
	// ================================================================
	// Bus slave state, one-hot.
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ACK  = 3'b010;
	localparam [2:0] ST_REL  = 3'b100;

	reg  [2:0]                state_ff;
	reg  [2:0]                nxt_state;
	reg                       wait_ff;
	reg  [31:0]               rdata_ff;
	reg  [31:0]               nxt_rdata;
	reg  [`RFS_LEN_W-1:0]     maxLen_ff;
	reg  [`RFS_NUM_CNT-1:0]   irqStat_ff;
	reg  [`RFS_NUM_CNT-1:0]   irqMask_ff;
	reg  [`RFS_NUM_CNT-1:0]   nxt_irqStat;
	reg                       irq_ff;
	wire [`RFS_NUM_CNT-1:0]   incVec;
	wire [`RFS_NUM_CNT-1:0]   clrVec;
	wire [`RFS_NUM_CNT-1:0]   satVec;
	wire [`RFS_CNT_W*`RFS_NUM_CNT-1:0] cntFlat;
	wire                      wrTake;

	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign irq             = irq_ff;

	// A write takes effect only at the edge where the master sees
	// waitrequest low, so a master that aborts early changes nothing.
	assign wrTake = (state_ff == ST_ACK) && avs_write;

	function [`RFS_NUM_CNT-1:0] cnt_hit;
		input [7:0] addr;
		begin
			if (addr == `RFS_SHORT_OFS) begin
				cnt_hit = 4'h1;
			end else if (addr == `RFS_LONG_OFS) begin
				cnt_hit = 4'h2;
			end else if (addr == `RFS_RESID_OFS) begin
				cnt_hit = 4'h4;
			end else if (addr == `RFS_MCAST_OFS) begin
				cnt_hit = 4'h8;
			end else begin
				cnt_hit = 4'h0;
			end
		end
	endfunction

	// Write data is ignored for counters; a bare write clears.
	assign clrVec = wrTake ? cnt_hit(avs_address) : 4'h0;

	// ================================================================
	// Frame classification and counters.
	rfs_frame_classify #(
		.LEN_W         (`RFS_LEN_W)
	) u_classify (
		.frameDone     (frameDone),
		.frameLen      (frameLen),
		.frameResidual (frameResidual),
		.frameMcast    (frameMcast),
		.maxLen        (maxLen_ff),
		.incShort      (incVec[`RFS_IDX_SHORT]),
		.incLong       (incVec[`RFS_IDX_LONG]),
		.incResid      (incVec[`RFS_IDX_RESID]),
		.incMcast      (incVec[`RFS_IDX_MCAST])
	);

	genvar gi;
	generate
		for (gi = 0; gi < `RFS_NUM_CNT; gi = gi + 1) begin : g_cnt
			rfs_sat_counter #(
				.WIDTH     (`RFS_CNT_W)
			) u_cnt (
				.sys_clk   (sys_clk),
				.rst       (rst),
				.clr       (clrVec[gi]),
				.inc       (incVec[gi]),
				.count     (cntFlat[gi*`RFS_CNT_W +: `RFS_CNT_W]),
				.saturated (satVec[gi])
			);
		end
	endgenerate

	// ================================================================
	// Interrupt: a status bit is set when an increment reaches its counter while it is already saturated.
	// Set beats the write-one clear so a saturation is never lost.
	always @* begin
		nxt_irqStat = irqStat_ff;
		if (wrTake && (avs_address == `RFS_IRQ_STAT_OFS) &&
		    avs_byteenable[0]) begin
			nxt_irqStat = irqStat_ff & ~avs_writedata[`RFS_NUM_CNT-1:0];
		end
		nxt_irqStat = nxt_irqStat | (incVec & satVec);
	end

	// ================================================================
	// Read mux.
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (avs_address == `RFS_SHORT_OFS) begin
			nxt_rdata[15:0] = cntFlat[15:0];
		end else if (avs_address == `RFS_LONG_OFS) begin
			nxt_rdata[15:0] = cntFlat[31:16];
		end else if (avs_address == `RFS_RESID_OFS) begin
			nxt_rdata[15:0] = cntFlat[47:32];
		end else if (avs_address == `RFS_MCAST_OFS) begin
			nxt_rdata[15:0] = cntFlat[63:48];
		end else if (avs_address == `RFS_MAXLEN_OFS) begin
			nxt_rdata[15:0] = maxLen_ff;
		end else if (avs_address == `RFS_IRQ_STAT_OFS) begin
			nxt_rdata[3:0] = irqStat_ff;
		end else if (avs_address == `RFS_IRQ_MASK_OFS) begin
			nxt_rdata[3:0] = irqMask_ff;
		end else begin
			nxt_rdata = 32'h0000_0000;
		end
	end

	// ================================================================
	// Handshake: one wait cycle, then a one-cycle release of
	// waitrequest, then a recovery cycle so a held request is not
	// taken twice.
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (avs_read || avs_write) begin
					nxt_state = ST_ACK;
				end
			end
			ST_ACK: begin
				nxt_state = ST_REL;
			end
			ST_REL: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff   <= ST_IDLE;
			wait_ff    <= 1'b1;
			rdata_ff   <= 32'h0000_0000;
			maxLen_ff  <= `RFS_MAXLEN_RST;
			irqStat_ff <= `RFS_IRQ_RST;
			irqMask_ff <= `RFS_IRQ_RST;
			irq_ff     <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			wait_ff    <= !(state_ff == ST_IDLE &&
			                (avs_read || avs_write));
			irqStat_ff <= nxt_irqStat;
			irq_ff     <= |(nxt_irqStat & irqMask_ff);
			if (state_ff == ST_IDLE && avs_read) begin
				rdata_ff <= nxt_rdata;
			end
			if (wrTake && avs_address == `RFS_MAXLEN_OFS) begin
				if (avs_byteenable[0]) begin
					maxLen_ff[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					maxLen_ff[15:8] <= avs_writedata[15:8];
				end
			end
			if (wrTake && avs_address == `RFS_IRQ_MASK_OFS &&
			    avs_byteenable[0]) begin
				irqMask_ff <= avs_writedata[`RFS_NUM_CNT-1:0];
			end
		end
	end
endmodule

// >>> rtl/rfs_sat_counter.v
`timescale 1ns/100ps

// ====================================================================
// Saturating counter with a clear that beats the increment.
module rfs_sat_counter #(
	parameter WIDTH = 16
) (
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             clr,
	input  wire             inc,
	output wire [WIDTH-1:0] count,
	output wire             saturated
);
	reg  [WIDTH-1:0] count_ff;
	reg  [WIDTH-1:0] nxt_count;

	assign count     = count_ff;
	assign saturated = &count_ff;

	always @* begin
		nxt_count = count_ff;
		if (clr) begin
			nxt_count = {WIDTH{1'b0}};
		end else if (inc && !saturated) begin
			nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_ff <= {WIDTH{1'b0}};
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule

// >>> testbench/rfs_frame_src.sv
`timescale 1ns/100ps
// ====================
// Receive classifier stand-in; fields are scrambled between strobes.
module rfs_frame_src (
	input  logic        sys_clk,
	output logic        frameDone,
	output logic [15:0] frameLen,
	output logic        frameResidual,
	output logic        frameMcast
);
	initial begin
		frameDone = 1'b0;
		frameLen = 16'hA5A5;
		frameResidual = 1'b1;
		frameMcast = 1'b1;
	end
	// Holding the strobe for n cycles reports n frames back to back.
	task send(input int n, input logic [15:0] len, input logic res, mc);
		frameDone <= 1'b1;
		frameLen <= len;
		frameResidual <= res;
		frameMcast <= mc;
		repeat (n) @(posedge sys_clk);
		frameDone <= 1'b0;
		frameLen <= ~len;
		frameResidual <= ~res;
		frameMcast <= ~mc;
	endtask
endmodule

// >>> testbench/rfs_rx_stats_chk.sv
`timescale 1ns/100ps
// ====================
// Bus timing and interrupt checks at the block's ports.
module rfs_rx_stats_chk (
	input logic        sys_clk,
	input logic        rst,
	input logic [7:0]  avs_address,
	input logic        avs_read,
	input logic        avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0]  avs_byteenable,
	input logic [31:0] avs_readdata,
	input logic        avs_waitrequest,
	input logic        frameDone,
	input logic [15:0] frameLen,
	input logic        frameResidual,
	input logic        frameMcast,
	input logic        irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_lat; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
	property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	property p_idle;
		!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
	endproperty
	property p_hi;
		avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
	endproperty
	property p_unmap;
		avs_read && !avs_waitrequest && avs_address > 8'h18
			|-> avs_readdata == 32'h00000000;
	endproperty
	property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
	// A mask write may also raise the level, so writes are causes too.
	property p_irqup;
		$rose(irq) |-> $past(frameDone) || $past(frameDone, 2)
			|| $past(avs_write) || $past(avs_write, 2);
	endproperty
	property p_irqdn; $fell(irq) |-> $past(avs_write) || $past(avs_write, 2);
	endproperty
	a_lat: assert property (p_lat) else $error("late answer");
	a_one: assert property (p_one) else $error("long answer");
	a_idle: assert property (p_idle) else $error("stray answer");
	a_hi: assert property (p_hi) else $error("upper bits set");
	a_unmap: assert property (p_unmap) else $error("bad data");
	a_hold: assert property (p_hold) else $error("data moved");
	a_irqup: assert property (p_irqup) else $error("irq rose");
	a_irqdn: assert property (p_irqdn) else $error("irq fell");
	c_wr: cover property (avs_write && !avs_waitrequest);
	c_irq: cover property (irq);
	c_res: cover property (frameDone && frameResidual);
endmodule
bind rfs_rx_stats rfs_rx_stats_chk i_rfs_rx_stats_chk (.*);

// >>> testbench/rfs_rx_stats_tb.sv
`timescale 1ns/100ps
`include "rfs_map.vh"
// ====================
// Register-level tests of the receive statistics block.
module rfs_rx_stats_tb;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic [7:0]  avs_address = 0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        frameDone;
	logic        frameResidual;
	logic        frameMcast;
	logic        irq;
	logic [15:0] frameLen;
	int          numErrors = 0;
	int          nChecks = 0;
	always #10 sys_clk = ~sys_clk;
	rfs_rx_stats i_rfs_rx_stats (.*, .avs_byteenable(4'hF));
	rfs_frame_src i_rfs_frame_src (.*);
	task acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task chk(input string s, input logic [31:0] e, g);
		nChecks++;
		if (g !== e) begin
			numErrors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task fr(input logic [15:0] len, input logic res, mc);
		i_rfs_frame_src.send(1, len, res, mc);
		@(posedge sys_clk);
	endtask
	task print_verdict;
		$display("Checks %0d, mismatches %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge sys_clk);
		numErrors++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) rc(8'(i * 4), i == 4 ? 32'h05EE : 0);
		wr(8'h1C, 32'h0000FFFF);
		rc(8'h1C, 32'h0);
		fr(16'd63, 0, 0);
		fr(16'd64, 0, 0);
		fr(16'd1518, 0, 0);
		fr(16'd1519, 0, 0);
		fr(16'd1519, 1, 0);
		fr(16'd40, 1, 1);
		rc(`RFS_SHORT_OFS, 32'h2);
		rc(`RFS_LONG_OFS, 32'h1);
		rc(`RFS_RESID_OFS, 32'h2);
		rc(`RFS_MCAST_OFS, 32'h1);
		wr(`RFS_RESID_OFS, 32'h0000ABCD);
		rc(`RFS_RESID_OFS, 32'h0);
		wr(`RFS_MAXLEN_OFS, 32'h00000064);
		fr(16'd101, 0, 0);
		fr(16'd100, 0, 0);
		rc(`RFS_LONG_OFS, 32'h2);
		// The frame is held back one cycle so that it meets the clear
		// at the edge where the write lands.
		fork
			wr(`RFS_SHORT_OFS, 32'h0);
			begin
				@(posedge sys_clk);
				i_rfs_frame_src.send(1, 16'd10, 0, 0);
			end
		join
		rc(`RFS_SHORT_OFS, 32'h0);
		wr(`RFS_IRQ_MASK_OFS, 32'h1);
		i_rfs_frame_src.send(65536, 16'd20, 0, 0);
		@(posedge sys_clk);
		rc(`RFS_SHORT_OFS, 32'h0000FFFF);
		rc(`RFS_LONG_OFS, 32'h2);
		rc(`RFS_IRQ_STAT_OFS, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`RFS_IRQ_MASK_OFS, 32'h0);
		@(posedge sys_clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`RFS_IRQ_MASK_OFS, 32'h1);
		wr(`RFS_IRQ_STAT_OFS, 32'h1);
		rc(`RFS_IRQ_STAT_OFS, 32'h0);
		@(posedge sys_clk);
		chk("irq", 32'h0, {31'h0, irq});
		print_verdict;
	end
endmodule
